//--- verilog/gppi_top.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - pins claimed by a peripheral function are never driven by the port; the registered output enable drops one cycle after the claim rises
// RL2 - software sets each pin's direction at any time
// RL3 - one write sets or clears several outputs, others untouched
// RL4 - one write loads the output value of a whole port
// RL5 - per-pin word reads one pin or drives one pin alone
// RL6 - after reset all pins are inputs and all interrupts are off
// RL7 - pins can interrupt on level, rising, falling or both edges
// RL8 - eight pin-interrupt channels each select any pin, edge or level
// RL9 - two group units each give one combined interrupt from chosen pins
// RL10 - any pin or combination of pins can trigger a group interrupt
// RL11 - registers sit directly on the fast system bus, zero wait
// RL12 - each interrupt unit drives its own line to the interrupt controller
// RL13 - level requests follow the pin; edge requests latch until cleared
module gppi_top
  import gppi_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic [NPIN-1:0] FUNC_CLAIM,
  output gppi_pad_s PIN_DRV,
  output logic [NPINT-1:0] PINT_IRQ,
  output logic [NGRP-1:0] GROUP_IRQ
);

  gppi_state_s st_r;
  gppi_state_s st_nxt;
  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_view;
  logic wr;
  logic setup;

  function automatic logic in_rng(input int a, input int base, input int n);
    return (a[1:0] == 2'b00) && (a >= base) && (a < base + 4 * n);
  endfunction : in_rng

  function automatic int word_ix(input int a, input int base);
    return (a - base) >> 2;
  endfunction : word_ix

  function automatic logic pin_at(input logic [NPIN-1:0] v, input logic [SELW-1:0] i);
    return v[i];
  endfunction : pin_at

  gppi_sync #(
    .W(NPIN)
  ) u_sync (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .D(PIN_IN),
    .Q(pin_s)
  );

  assign wr = PSEL & PENABLE & PWRITE;
  assign setup = PSEL & ~PENABLE;
  // outputs read back their latch, inputs the synchronised pad
  assign pin_view = (st_r.dir & st_r.out) | (~st_r.dir & pin_s);

  always_comb begin
    int a;
    int ix;
    int gb;
    logic hit;
    logic v;
    logic eset;
    logic lvl;
    logic [31:0] rd;
    logic [NPINT-1:0] clr;
    a = int'(PADDR);
    ix = 0;
    gb = 0;
    hit = 1'b0;
    v = 1'b0;
    eset = 1'b0;
    lvl = 1'b0;
    rd = '0;
    clr = '0;
    st_nxt = st_r;
    // zero-wait slave on the fast bus
    if (in_rng(a, int'(OFS_DIR), NPORT)) begin // RL11
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_DIR));
      rd = st_r.dir[ix*PORT_W +: PORT_W];
      if (wr) begin
        st_nxt.dir[ix*PORT_W +: PORT_W] = PWDATA; // RL2
      end
    end
    if (in_rng(a, int'(OFS_PORT), NPORT)) begin
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_PORT));
      rd = pin_view[ix*PORT_W +: PORT_W];
      if (wr) begin
        st_nxt.out[ix*PORT_W +: PORT_W] = PWDATA; // RL4
      end
    end
    if (in_rng(a, int'(OFS_SET), NPORT)) begin
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_SET));
      if (wr) begin
        st_nxt.out[ix*PORT_W +: PORT_W] = st_r.out[ix*PORT_W +: PORT_W] | PWDATA; // RL3
      end
    end
    if (in_rng(a, int'(OFS_CLR), NPORT)) begin
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_CLR));
      if (wr) begin
        st_nxt.out[ix*PORT_W +: PORT_W] = st_r.out[ix*PORT_W +: PORT_W] & ~PWDATA; // RL3
      end
    end
    if (in_rng(a, int'(OFS_PIN), NPIN)) begin
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_PIN));
      rd = {31'h0, pin_at(pin_view, SELW'(ix))}; // RL5
      if (wr) begin
        st_nxt.out[ix] = PWDATA[0]; // RL5
      end
    end
    if (in_rng(a, int'(OFS_PINT_SEL), NPINT)) begin
      hit = 1'b1;
      ix = word_ix(a, int'(OFS_PINT_SEL));
      rd = 32'(st_r.sel[ix]);
      if (wr) begin
        st_nxt.sel[ix] = PWDATA[SELW-1:0]; // RL8
      end
    end
    if (PADDR == OFS_PINT_MODE) begin
      hit = 1'b1;
      rd = 32'(st_r.mode);
      if (wr) begin
        st_nxt.mode = PWDATA[NPINT-1:0];
      end
    end
    if (PADDR == OFS_PINT_RISE) begin
      hit = 1'b1;
      rd = 32'(st_r.rise);
      if (wr) begin
        st_nxt.rise = PWDATA[NPINT-1:0];
      end
    end
    if (PADDR == OFS_PINT_FALL) begin
      hit = 1'b1;
      rd = 32'(st_r.fall);
      if (wr) begin
        st_nxt.fall = PWDATA[NPINT-1:0];
      end
    end
    if (PADDR == OFS_PINT_STAT) begin
      hit = 1'b1;
      rd = 32'(st_r.pint_irq);
      if (wr) begin
        clr = PWDATA[NPINT-1:0];
      end
    end
    for (int g = 0; g < NGRP; g++) begin
      gb = g * int'(GRP_STEP);
      if (in_rng(a, int'(OFS_GRP_ENA) + gb, NPORT)) begin
        hit = 1'b1;
        ix = word_ix(a, int'(OFS_GRP_ENA) + gb);
        rd = st_r.gena[g][ix*PORT_W +: PORT_W];
        if (wr) begin
          st_nxt.gena[g][ix*PORT_W +: PORT_W] = PWDATA; // RL10
        end
      end
      if (in_rng(a, int'(OFS_GRP_POL) + gb, NPORT)) begin
        hit = 1'b1;
        ix = word_ix(a, int'(OFS_GRP_POL) + gb);
        rd = st_r.gpol[g][ix*PORT_W +: PORT_W];
        if (wr) begin
          st_nxt.gpol[g][ix*PORT_W +: PORT_W] = PWDATA;
        end
      end
    end
    // answer is prepared in the setup cycle so the access phase needs no wait
    if (setup) begin
      st_nxt.rdata = rd;
      st_nxt.err = ~hit;
    end
    // moving a selection can fake one edge; clear flags after reselecting
    for (int k = 0; k < NPINT; k++) begin
      v = pin_at(pin_s, st_r.sel[k]); // RL8
      eset = (st_r.rise[k] & v & ~st_r.prev[k]) | (st_r.fall[k] & ~v & st_r.prev[k]); // RL7
      st_nxt.flag[k] = eset | (st_r.flag[k] & ~clr[k]); // RL13
      st_nxt.prev[k] = v;
      lvl = st_r.rise[k] & (v == st_r.fall[k]); // RL7
      st_nxt.pint_irq[k] = st_r.mode[k] ? lvl : st_nxt.flag[k]; // RL13
    end
    for (int g = 0; g < NGRP; g++) begin
      st_nxt.grp_irq[g] = |(st_r.gena[g] & ~(pin_s ^ st_r.gpol[g])); // RL9
    end
    st_nxt.oe = st_nxt.dir & ~FUNC_CLAIM; // RL1
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_r <= '0;
      st_r.dir <= RST_DIR; // RL6
      st_r.out <= RST_OUT;
      st_r.rise <= RST_PINT_EN; // RL6
      st_r.fall <= RST_PINT_EN;
      st_r.gena <= {NGRP{RST_GRP_ENA}}; // RL6
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PREADY = 1'b1; // RL11
  assign PSLVERR = PSEL & PENABLE & st_r.err;
  assign PRDATA = st_r.rdata;
  // one driver for the whole carrier; member-wise drivers would split the variable
  assign PIN_DRV = '{out: st_r.out, oe: st_r.oe};
  assign PINT_IRQ = st_r.pint_irq; // RL12
  assign GROUP_IRQ = st_r.grp_irq; // RL12

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  sequence s_wr(logic [AW-1:0] ofs);
    PSEL && PENABLE && PWRITE && (PADDR == ofs);
  endsequence

  sequence s_setup(logic [AW-1:0] ofs);
    PSEL && !PENABLE && (PADDR == ofs) ##1 PSEL && PENABLE;
  endsequence

  a_reset_quiet: assert property ($fell(RESET) |-> // RL6
    (PIN_DRV.oe == '0) && (PINT_IRQ == '0) && (GROUP_IRQ == '0))
    else $error("pin driven or interrupt up right after reset");

  a_claim_no_drive: assert property (!$fell(RESET) |-> // RL1
    ((PIN_DRV.oe & $past(FUNC_CLAIM)) == '0))
    else $error("claimed pin still driven");

  a_dir_write: assert property (s_wr(OFS_DIR) |=> // RL2
    PIN_DRV.oe[PORT_W-1:0] == ($past(PWDATA) & ~$past(FUNC_CLAIM[PORT_W-1:0])))
    else $error("direction write not applied");

  a_set_pins: assert property (s_wr(OFS_SET) |=> // RL3
    PIN_DRV.out[PORT_W-1:0] == ($past(PIN_DRV.out[PORT_W-1:0]) | $past(PWDATA)))
    else $error("set write wrong");

  a_clr_pins: assert property (s_wr(OFS_CLR) |=> // RL3
    PIN_DRV.out[PORT_W-1:0] == ($past(PIN_DRV.out[PORT_W-1:0]) & ~$past(PWDATA)))
    else $error("clear write wrong");

  a_port_write: assert property (s_wr(OFS_PORT) |=> // RL4
    PIN_DRV.out[PORT_W-1:0] == $past(PWDATA))
    else $error("whole port write wrong");

  // any word of the per-pin window, so the pin picked by the address is the one checked
  sequence s_pin_wr;
    PSEL && PENABLE && PWRITE && (PADDR[AW-1:8] == OFS_PIN[AW-1:8]) && (PADDR[1:0] == 2'b00);
  endsequence

  a_pin_write: assert property (s_pin_wr |=> // RL5
    (PIN_DRV.out[$past(PADDR[SELW+1:2])] == $past(PWDATA[0])) &&
    (((PIN_DRV.out ^ $past(PIN_DRV.out)) & ~(NPIN'(1) << $past(PADDR[SELW+1:2]))) == '0))
    else $error("single pin write touched other pins");

  // every channel gets the same checks, so each mode in use is reached
  for (genvar k = 0; k < NPINT; k++) begin : g_pint_chk
    a_rise_flag: assert property (!st_r.mode[k] && st_r.rise[k] && // RL8
      pin_at(pin_s, st_r.sel[k]) && !st_r.prev[k] |=> PINT_IRQ[k])
      else $error("rising edge missed");

    // one cycle only: a clear may land in the very next access phase
    a_edge_hold: assert property (!st_r.mode[k] && PINT_IRQ[k] && !wr |=> // RL13
      PINT_IRQ[k])
      else $error("edge request dropped without clear");

    a_stat_clear: assert property (wr && (PADDR == OFS_PINT_STAT) && PWDATA[k] && // RL13
      !st_r.mode[k] && (pin_at(pin_s, st_r.sel[k]) == st_r.prev[k]) |=> !PINT_IRQ[k])
      else $error("edge request survived its clear");

    a_level_follow: assert property (st_r.mode[k] && st_r.rise[k] && !wr && // RL7
      (pin_at(pin_s, st_r.sel[k]) == st_r.fall[k]) |=> PINT_IRQ[k])
      else $error("level request not raised");
  end

  a_group_off: assert property ((st_r.gena[0] == '0) && !wr |=> !GROUP_IRQ[0]) // RL9
    else $error("group interrupt with no pins enabled");

  // latch only moves on a write; catches a stray decode hit
  a_out_hold: assert property (!wr |=> $stable(PIN_DRV.out)) // RL3
    else $error("output latch moved without a write");

  // read data must stand through the access phase
  a_rdata_hold: assert property (!setup |=> $stable(PRDATA)) // RL11
    else $error("read data moved outside a setup cycle");

  a_err_unmapped: assert property (s_setup(16'h0ffc) |-> PSLVERR && PREADY) // RL11
    else $error("unmapped access not flagged");

endmodule : gppi_top

//--- verilog/gppi_pkg.sv
package gppi_pkg;

  localparam int NPORT = 2;
  localparam int PORT_W = 32;
  localparam int NPIN = NPORT * PORT_W;
  localparam int NPINT = 8;
  localparam int NGRP = 2;
  localparam int SELW = $clog2(NPIN);
  localparam int AW = 16;

  // byte offsets; port-indexed registers step by one word per port
  localparam logic [AW-1:0] OFS_DIR = 16'h0000;
  localparam logic [AW-1:0] OFS_PORT = 16'h0020;
  localparam logic [AW-1:0] OFS_SET = 16'h0040;
  localparam logic [AW-1:0] OFS_CLR = 16'h0060;
  localparam logic [AW-1:0] OFS_PINT_SEL = 16'h0100;
  localparam logic [AW-1:0] OFS_PINT_MODE = 16'h0120;
  localparam logic [AW-1:0] OFS_PINT_RISE = 16'h0124;
  localparam logic [AW-1:0] OFS_PINT_FALL = 16'h0128;
  localparam logic [AW-1:0] OFS_PINT_STAT = 16'h012c;
  localparam logic [AW-1:0] OFS_GRP_ENA = 16'h0200;
  localparam logic [AW-1:0] OFS_GRP_POL = 16'h0210;
  localparam logic [AW-1:0] GRP_STEP = 16'h0020;
  localparam logic [AW-1:0] OFS_PIN = 16'h1000;

  localparam logic [NPIN-1:0] RST_DIR = '0;
  localparam logic [NPIN-1:0] RST_OUT = '0;
  localparam logic [NPINT-1:0] RST_PINT_EN = '0;
  localparam logic [NPIN-1:0] RST_GRP_ENA = '0;

  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
  } gppi_pad_s;

  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPINT-1:0][SELW-1:0] sel;
    logic [NPINT-1:0] mode;
    logic [NPINT-1:0] rise;
    logic [NPINT-1:0] fall;
    logic [NPINT-1:0] flag;
    logic [NPINT-1:0] prev;
    logic [NPINT-1:0] pint_irq;
    logic [NGRP-1:0][NPIN-1:0] gena;
    logic [NGRP-1:0][NPIN-1:0] gpol;
    logic [NGRP-1:0] grp_irq;
    logic [31:0] rdata;
    logic err;
  } gppi_state_s;

endpackage : gppi_pkg

//--- verilog/gppi_sync.sv
`timescale 1ns/1ps
module gppi_sync #(
  parameter int W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gppi_sync_s;

  gppi_sync_s st_r;
  gppi_sync_s st_nxt;

  // a bit only moves once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = D;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign Q = st_r.q;

endmodule : gppi_sync

//--- tb/gppi_pin_model.sv
`timescale 1ns/1ps
module gppi_pin_model
  import gppi_pkg::*;
(
  input wire logic [NPIN-1:0] ext_lvl,
  input wire gppi_pad_s drv,
  output logic [NPIN-1:0] pad
);
  // a driven pin shows the port's level, otherwise the outside source wins
  assign pad = (drv.oe & drv.out) | (~drv.oe & ext_lvl);
endmodule : gppi_pin_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import gppi_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [AW-1:0] addr;
    logic [31:0] data;
    logic err;
  } gppi_row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  // pin 63 claimed; its outside level equals the latch so either read view agrees
  logic [NPIN-1:0] claim = 64'h8000_0000_0000_0000;
  logic [NPIN-1:0] ext = 64'h8000_0000_a5a5_0000;
  logic [NPIN-1:0] pad;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  gppi_pad_s drv;
  logic [NPINT-1:0] pint_irq;
  logic [NGRP-1:0] grp_irq;
  int fails = 0;
  int n_compared = 0;

  gppi_row_s rows [18] = '{
    '{1'b0, OFS_PINT_RISE, 32'h0, 1'b0}, '{1'b1, OFS_DIR, 32'h0000_ffff, 1'b0},
    '{1'b1, OFS_PORT, 32'h1234_5678, 1'b0}, '{1'b0, OFS_PORT, 32'ha5a5_5678, 1'b0},
    '{1'b1, OFS_SET, 32'h81, 1'b0}, '{1'b0, OFS_PORT, 32'ha5a5_56f9, 1'b0},
    '{1'b1, OFS_CLR, 32'h70, 1'b0}, '{1'b0, OFS_PORT, 32'ha5a5_5689, 1'b0},
    '{1'b0, OFS_SET, 32'h0, 1'b0}, '{1'b1, OFS_PIN + 16'hc, 32'h0, 1'b0},
    '{1'b0, OFS_PIN + 16'hc, 32'h0, 1'b0}, '{1'b0, OFS_PIN + 16'h1c, 32'h1, 1'b0},
    '{1'b0, OFS_PORT, 32'ha5a5_5681, 1'b0}, '{1'b0, OFS_DIR, 32'h0000_ffff, 1'b0},
    '{1'b1, OFS_DIR + 16'h4, 32'hffff_ffff, 1'b0},
    '{1'b1, OFS_PORT + 16'h4, 32'hdead_beef, 1'b0},
    '{1'b0, OFS_PORT + 16'h4, 32'hdead_beef, 1'b0}, '{1'b0, 16'h0ffc, 32'h0, 1'b1}};

  always #4 clk = ~clk;

  gppi_top i_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pad), .FUNC_CLAIM(claim), .PIN_DRV(drv),
    .PINT_IRQ(pint_irq), .GROUP_IRQ(grp_irq));
  gppi_pin_model i_pins (.ext_lvl(ext), .drv(drv), .pad(pad));

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_line(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_line

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    chk_word("wait cycles", 32'h1, 32'(i));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  // pad change reaches the lines within five edges; six leaves margin
  task automatic pin(input int n, input logic v);
    @(posedge clk);
    ext[n] <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : pin

  initial begin
    logic [31:0] rd;
    logic err;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_line("oe after reset", '0, drv.oe);
    chk_line("irq after reset", '0, {pint_irq, grp_irq});
    foreach (rows[r]) begin
      apb(rows[r].wr, rows[r].addr, rows[r].data, rd, err);
      if (!rows[r].wr) begin
        chk_word("read data", rows[r].data, rd);
      end
      chk_word("slave error", 32'(rows[r].err), 32'(err));
    end
    @(negedge clk);
    chk_line("output enable", 64'h7fff_ffff_0000_ffff, drv.oe);
    chk_word("port1 drive", 32'hdead_beef, drv.out[63:32]);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_PINT_SEL + AW'(4 * k), 32'h14);
    end
    // ch0 rise, ch1 fall, ch2 both edges, ch3 level high
    wr(OFS_PINT_MODE, 32'h08);
    wr(OFS_PINT_RISE, 32'h0d);
    wr(OFS_PINT_FALL, 32'h0e);
    wr(OFS_PINT_STAT, 32'hff);
    pin(20, 1'b0);
    chk_line("pin irq idle", '0, pint_irq);
    pin(20, 1'b1);
    chk_line("pin irq rise", 64'h0d, pint_irq);
    pin(20, 1'b0);
    chk_line("pin irq fall", 64'h07, pint_irq);
    apb(1'b0, OFS_PINT_STAT, 32'h0, rd, err);
    chk_word("pin irq status", 32'h07, rd);
    wr(OFS_PINT_STAT, 32'h0f);
    pin(20, 1'b0);
    chk_line("pin irq cleared", '0, pint_irq);
    // ch3 turned to level low while pin 20 sits low
    wr(OFS_PINT_FALL, 32'h06);
    pin(20, 1'b0);
    chk_line("pin irq level low", 64'h08, pint_irq);
    wr(OFS_GRP_ENA + GRP_STEP, 32'h0050_0000);
    wr(OFS_GRP_POL + GRP_STEP, 32'h0050_0000);
    pin(22, 1'b0);
    chk_line("group idle", '0, grp_irq);
    pin(22, 1'b1);
    chk_line("group pin22", 64'h2, grp_irq);
    pin(22, 1'b0);
    pin(20, 1'b1);
    chk_line("group pin20", 64'h2, grp_irq);
    // pin 15 handed to a peripheral while configured as output
    @(posedge clk);
    claim <= 64'h8000_0000_0000_8000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_line("oe after claim", 64'h7fff_ffff_0000_7fff, drv.oe);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_line("oe mid reset", '0, drv.oe);
    chk_line("irq mid reset", '0, {pint_irq, grp_irq});
    end_sim();
  end
endmodule : testbench
